// ### core/hef_pkg.sv
// Function
// - a one written to an event_clear bit clears that event; zero keeps it.
// - event_status reads bit 1 init, 2 brownout, 3 loop, 4 config pending.
// - event_enable masks events so only enabled ones raise host interrupt.
// - config-complete (bit 4) sets once after all requested loops finish.
// - with both configurations in use, they share one loop count and bit 4; a new config_start restarts the count.
// - loop-complete (bit 3) sets after every completed loop.
// - image_version 31-28 is build level: 0 debug, 1 or more release.
// - image_version holds minor in 27-20, major in 19-12, build in 11-0.
// - image_flip bit 4 set mirrors the image along the long side.
// - image_flip bit 0 set mirrors the image along the short side.
// - the host can read every register of the bank and write all but image_version.
package hef_pkg;

  localparam logic [15:0] ADDR_EVENT_CLEAR = 16'h0000;
  localparam logic [15:0] ADDR_EVENT_STATUS = 16'h0004;
  localparam logic [15:0] ADDR_EVENT_ENABLE = 16'h0008;
  localparam logic [15:0] ADDR_IMAGE_VERSION = 16'h0010;
  localparam logic [15:0] ADDR_IMAGE_FLIP = 16'h0020;

  localparam int EVENT_COUNT = 5;
  localparam int BIT_INIT_DONE = 1;
  localparam int BIT_BROWNOUT = 2;
  localparam int BIT_LOOP_COMPLETE = 3;
  localparam int BIT_CONFIG_COMPLETE = 4;
  localparam logic [4:0] EVENT_MASK = 5'h1E;

  localparam int BIT_LONG_SIDE_MIRROR = 4;
  localparam int BIT_SHORT_SIDE_MIRROR = 0;

  localparam int VER_LEVEL_LSB = 28;
  localparam int VER_MINOR_LSB = 20;
  localparam int VER_MAJOR_LSB = 12;
  localparam int VER_BUILD_LSB = 0;

  localparam logic [4:0] RESET_EVENT_ENABLE = 5'h00;
  localparam logic RESET_FLIP = 1'b0;
  localparam logic [11:0] RESET_LOOP_COUNT = 12'h000;
  localparam logic [31:0] RESET_READ_DATA = 32'h00000000;

endpackage

// ### core/hef_sticky.sv
`timescale 1ns/1ps
module hef_sticky
(
  input wire logic clock,
  input wire logic reset,
  input wire logic set,
  input wire logic clear,
  output logic pending
);

  typedef struct packed
  {
    logic pending;
  } hef_sticky_state_type;

  hef_sticky_state_type state;
  hef_sticky_state_type next_state;

  always_comb
  begin
    next_state = state;
    // set wins so an event landing on the clear cycle survives
    next_state.pending = set | (state.pending & ~clear);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign pending = state.pending;

endmodule

// ### core/hef_regs.sv
`timescale 1ns/1ps
module hef_regs
#(
  // version fields: arbitrary values
  parameter logic [3:0] BUILD_LEVEL = 4'h1,
  parameter logic [7:0] VERSION_MINOR = 8'h02,
  parameter logic [7:0] VERSION_MAJOR = 8'h03,
  parameter logic [11:0] BUILD_NUMBER = 12'h004
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic init_done_pulse,
  input wire logic brownout_pulse,
  input wire logic config_start,
  input wire logic loop_end,
  input wire logic [11:0] loop_total,
  output logic host_irq,
  output logic long_side_mirror,
  output logic short_side_mirror
);

  localparam logic [31:0] VERSION_VALUE =
    {BUILD_LEVEL, VERSION_MINOR, VERSION_MAJOR, BUILD_NUMBER};

  typedef struct packed
  {
    logic [4:0] enable;
    logic long_mirror;
    logic short_mirror;
    logic irq;
    logic [31:0] rdata;
    logic rvalid;
    logic [11:0] loop_count;
  } hef_regs_state_type;

  hef_regs_state_type state;
  hef_regs_state_type next_state;

  logic [4:0] pending;
  logic [4:0] event_set;
  logic [4:0] event_clear;
  logic last_loop;
  logic config_done;
  logic [11:0] loop_next;
  logic wr_clear;
  logic wr_status;

  // a loop total of zero is invalid, treated as a single loop
  assign loop_next = state.loop_count + 12'h001;
  assign last_loop = (loop_next >= loop_total) || (loop_total == 12'h000);
  assign config_done = loop_end && last_loop;

  assign wr_clear = reg_write && (reg_addr == hef_pkg::ADDR_EVENT_CLEAR);
  assign wr_status = reg_write && (reg_addr == hef_pkg::ADDR_EVENT_STATUS);

  always_comb
  begin
    event_set = 5'h00;
    event_set[hef_pkg::BIT_INIT_DONE] = init_done_pulse;
    event_set[hef_pkg::BIT_BROWNOUT] = brownout_pulse;
    event_set[hef_pkg::BIT_LOOP_COMPLETE] = loop_end;
    event_set[hef_pkg::BIT_CONFIG_COMPLETE] = config_done;
    // a write of ones to the status word raises events, for software test
    if (wr_status)
    begin
      event_set = event_set | (reg_wdata[4:0] & hef_pkg::EVENT_MASK);
    end
  end

  assign event_clear = wr_clear ?
    (reg_wdata[4:0] & hef_pkg::EVENT_MASK) : 5'h00;

  genvar g;
  generate
    for (g = 0; g < hef_pkg::EVENT_COUNT; g++)
    begin : gen_event
      if (hef_pkg::EVENT_MASK[g])
      begin : gen_live
        hef_sticky u_sticky
        (
          .clock(clock),
          .reset(reset),
          .set(event_set[g]),
          .clear(event_clear[g]),
          .pending(pending[g])
        );
      end
      else
      begin : gen_reserved
        assign pending[g] = 1'b0;
      end
    end
  endgenerate

  always_comb
  begin
    next_state = state;
    next_state.rvalid = reg_read;
    // each config_start restarts the one shared loop count, so a configuration
    // started mid-count drops the completion event of the earlier one
    if (config_start)
    begin
      next_state.loop_count = hef_pkg::RESET_LOOP_COUNT;
    end
    else if (loop_end)
    begin
      next_state.loop_count = last_loop ?
        hef_pkg::RESET_LOOP_COUNT : loop_next;
    end
    if (reg_write)
    begin
      case (reg_addr)
        hef_pkg::ADDR_EVENT_ENABLE:
        begin
          next_state.enable = reg_wdata[4:0] & hef_pkg::EVENT_MASK;
        end
        hef_pkg::ADDR_IMAGE_FLIP:
        begin
          next_state.long_mirror =
            reg_wdata[hef_pkg::BIT_LONG_SIDE_MIRROR];
          next_state.short_mirror =
            reg_wdata[hef_pkg::BIT_SHORT_SIDE_MIRROR];
        end
        default:
        begin
          // version is read-only; unmapped writes are dropped
          next_state.enable = state.enable;
        end
      endcase
    end
    next_state.irq = |(pending & state.enable);
    next_state.rdata = hef_pkg::RESET_READ_DATA;
    if (reg_read)
    begin
      case (reg_addr)
        hef_pkg::ADDR_EVENT_CLEAR,
        hef_pkg::ADDR_EVENT_STATUS:
        begin
          next_state.rdata = {27'h0000000, pending};
        end
        hef_pkg::ADDR_EVENT_ENABLE:
        begin
          next_state.rdata = {27'h0000000, state.enable};
        end
        hef_pkg::ADDR_IMAGE_VERSION:
        begin
          next_state.rdata = VERSION_VALUE;
        end
        hef_pkg::ADDR_IMAGE_FLIP:
        begin
          next_state.rdata = {27'h0000000, state.long_mirror,
            3'h0, state.short_mirror};
        end
        default:
        begin
          next_state.rdata = hef_pkg::RESET_READ_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state.enable <= hef_pkg::RESET_EVENT_ENABLE;
      state.long_mirror <= hef_pkg::RESET_FLIP;
      state.short_mirror <= hef_pkg::RESET_FLIP;
      state.irq <= 1'b0;
      state.rdata <= hef_pkg::RESET_READ_DATA;
      state.rvalid <= 1'b0;
      state.loop_count <= hef_pkg::RESET_LOOP_COUNT;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign host_irq = state.irq;
  assign long_side_mirror = state.long_mirror;
  assign short_side_mirror = state.short_mirror;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence clear_write_s;
    wr_clear && ((reg_wdata[4:0] & event_set) == 5'h00);
  endsequence

  sequence last_loop_s;
    loop_end && last_loop && !wr_clear;
  endsequence

  sequence version_read_s;
    reg_read && (reg_addr == hef_pkg::ADDR_IMAGE_VERSION);
  endsequence

  clear_event_a: assert property (
    clear_write_s |=> ((pending & $past(reg_wdata[4:0])) == 5'h00))
  else $error("written clear bit left event pending");

  set_wins_a: assert property (
    (event_set != 5'h00)
    |=> ((pending & $past(event_set)) == $past(event_set)))
  else $error("event lost on clear cycle");

  status_read_a: assert property (
    reg_read && (reg_addr == hef_pkg::ADDR_EVENT_STATUS)
    |=> reg_rvalid && (reg_rdata == {27'h0000000, $past(pending)}))
  else $error("status read mismatch");

  irq_mask_a: assert property (
    ##1 host_irq == |($past(pending) & $past(state.enable)))
  else $error("host interrupt does not follow enabled events");

  irq_idle_a: assert property (
    (state.enable == 5'h00) ##1 (state.enable == 5'h00) |-> !host_irq)
  else $error("interrupt raised with all events masked");

  config_once_a: assert property (
    last_loop_s |=> pending[hef_pkg::BIT_CONFIG_COMPLETE]
      ##0 (state.loop_count == hef_pkg::RESET_LOOP_COUNT))
  else $error("config complete missing after last loop");

  config_early_a: assert property (
    loop_end && !last_loop && !wr_status
      && !pending[hef_pkg::BIT_CONFIG_COMPLETE]
    |=> !pending[hef_pkg::BIT_CONFIG_COMPLETE])
  else $error("config complete raised before last loop");

  config_restart_a: assert property (
    config_start |=> (state.loop_count == hef_pkg::RESET_LOOP_COUNT))
  else $error("loop count not restarted for new configuration");

  loop_event_a: assert property (
    loop_end && !wr_clear |=> pending[hef_pkg::BIT_LOOP_COMPLETE])
  else $error("loop complete event missing");

  version_read_a: assert property (
    version_read_s |=> reg_rvalid && (reg_rdata[31:28] == BUILD_LEVEL)
      && (reg_rdata[27:0] == VERSION_VALUE[27:0]))
  else $error("version word mismatch");

  flip_long_a: assert property (
    reg_write && (reg_addr == hef_pkg::ADDR_IMAGE_FLIP)
    |=> long_side_mirror == $past(reg_wdata[hef_pkg::BIT_LONG_SIDE_MIRROR]))
  else $error("long side mirror not updated");

  flip_short_a: assert property (
    reg_write && (reg_addr == hef_pkg::ADDR_IMAGE_FLIP)
    |=> short_side_mirror == $past(reg_wdata[hef_pkg::BIT_SHORT_SIDE_MIRROR]))
  else $error("short side mirror not updated");

  reserved_zero_a: assert property (
    reg_read && (reg_addr != hef_pkg::ADDR_IMAGE_VERSION)
    |=> (reg_rdata[31:5] == 27'h0000000))
  else $error("reserved bits read nonzero");

endmodule

// ### sim/hef_event_src.sv
`timescale 1ns/1ps
module hef_event_src
(
  input wire logic clock,
  output logic init_done_pulse,
  output logic brownout_pulse,
  output logic config_start,
  output logic loop_end,
  output logic [11:0] loop_total
)
;
  initial
  begin
    {config_start, loop_end, brownout_pulse, init_done_pulse} = 4'h0;
    loop_total = 12'h001;
  end

  // sources only ever give one-cycle pulses, never held levels
  task automatic fire(input logic [3:0] sel);
    {config_start, loop_end, brownout_pulse, init_done_pulse} = sel;
    @(posedge clock);
    #1;
    {config_start, loop_end, brownout_pulse, init_done_pulse} = 4'h0;
    @(posedge clock);
    #1;
  endtask
endmodule

// ### sim/hef_regs_tb.sv
`timescale 1ns/1ps
module hef_regs_tb;
  localparam logic [3:0] LVL = 4'h1;
  localparam logic [7:0] MNR = 8'h02;
  localparam logic [7:0] MJR = 8'h03;
  localparam logic [11:0] BLD = 12'h004;
  localparam logic [31:0] VER = {LVL, MNR, MJR, BLD};
  logic clock, reset, reg_write, reg_read, host_irq;
  logic long_side_mirror, short_side_mirror, reg_rvalid;
  logic init_done_pulse, brownout_pulse, config_start, loop_end;
  logic [11:0] loop_total;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int errors;
  int n_compared;

  hef_regs u_hef_regs
  (
    .clock(clock), .reset(reset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .init_done_pulse(init_done_pulse), .brownout_pulse(brownout_pulse),
    .config_start(config_start), .loop_end(loop_end),
    .loop_total(loop_total), .host_irq(host_irq),
    .long_side_mirror(long_side_mirror),
    .short_side_mirror(short_side_mirror)
  );

  hef_event_src u_hef_event_src
  (
    .clock(clock), .init_done_pulse(init_done_pulse),
    .brownout_pulse(brownout_pulse), .config_start(config_start),
    .loop_end(loop_end), .loop_total(loop_total)
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic end_sim();
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_write = 1'b0;
    step(1);
  endtask

  // rvalid and data stand for one cycle only, so sample right after the edge
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    reg_read = 1'b1;
    reg_addr = a;
    step(1);
    reg_read = 1'b0;
    check({31'h0, reg_rvalid}, 32'h1);
    check(reg_rdata, exp);
    step(1);
  endtask

  initial
  begin
    repeat (2000) @(posedge clock);
    errors++;
    end_sim();
  end

  initial
  begin
    {reset, reg_write, reg_read} = 3'h4;
    reg_addr = 16'h0000;
    reg_wdata = 32'h00000000;
    repeat (4) @(posedge clock);
    #1;
    reset = 1'b0;
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h0);
    rd(hef_pkg::ADDR_EVENT_ENABLE, 32'h0);
    rd(hef_pkg::ADDR_IMAGE_VERSION, VER);
    rd(hef_pkg::ADDR_IMAGE_FLIP, 32'h0);
    rd(16'h000C, 32'h0);
    wr(hef_pkg::ADDR_IMAGE_VERSION, 32'hFFFFFFFF);
    rd(hef_pkg::ADDR_IMAGE_VERSION, VER);
    wr(hef_pkg::ADDR_IMAGE_FLIP, 32'hFFFFFFFF);
    rd(hef_pkg::ADDR_IMAGE_FLIP, 32'h11);
    check({30'h0, long_side_mirror, short_side_mirror}, 32'h3);
    wr(hef_pkg::ADDR_IMAGE_FLIP, 32'h10);
    check({30'h0, long_side_mirror, short_side_mirror}, 32'h2);
    wr(hef_pkg::ADDR_IMAGE_FLIP, 32'h01);
    check({30'h0, long_side_mirror, short_side_mirror}, 32'h1);
    u_hef_event_src.fire(4'h1);
    u_hef_event_src.fire(4'h2);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h06);
    rd(hef_pkg::ADDR_EVENT_CLEAR, 32'h06);
    check({31'h0, host_irq}, 32'h0);
    wr(hef_pkg::ADDR_EVENT_ENABLE, 32'hFFFFFFFF);
    rd(hef_pkg::ADDR_EVENT_ENABLE, 32'h1E);
    check({31'h0, host_irq}, 32'h1);
    wr(hef_pkg::ADDR_EVENT_CLEAR, 32'h02);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h04);
    check({31'h0, host_irq}, 32'h1);
    wr(hef_pkg::ADDR_EVENT_CLEAR, 32'h04);
    step(1);
    check({31'h0, host_irq}, 32'h0);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h0);
    wr(hef_pkg::ADDR_EVENT_ENABLE, 32'h08);
    u_hef_event_src.fire(4'h2);
    step(2);
    check({31'h0, host_irq}, 32'h0);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h04);
    wr(hef_pkg::ADDR_EVENT_STATUS, 32'hFFFFFFFF);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h1E);
    check({31'h0, host_irq}, 32'h1);
    wr(hef_pkg::ADDR_EVENT_CLEAR, 32'hFFFFFFFF);
    u_hef_event_src.loop_total = 12'h003;
    u_hef_event_src.fire(4'h8);
    u_hef_event_src.fire(4'h4);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h08);
    check({31'h0, host_irq}, 32'h1);
    wr(hef_pkg::ADDR_EVENT_CLEAR, 32'h08);
    u_hef_event_src.fire(4'h4);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h08);
    wr(hef_pkg::ADDR_EVENT_CLEAR, 32'h08);
    u_hef_event_src.fire(4'h4);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h18);
    wr(hef_pkg::ADDR_EVENT_CLEAR, 32'h18);
    u_hef_event_src.loop_total = 12'h001;
    u_hef_event_src.fire(4'h8);
    u_hef_event_src.fire(4'h4);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h18);
    wr(hef_pkg::ADDR_EVENT_CLEAR, 32'h18);
    // a new configuration mid-count must restart the one shared loop count
    u_hef_event_src.loop_total = 12'h002;
    u_hef_event_src.fire(4'h4);
    u_hef_event_src.fire(4'h8);
    u_hef_event_src.fire(4'h4);
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h08);
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    rd(hef_pkg::ADDR_EVENT_STATUS, 32'h0);
    rd(hef_pkg::ADDR_IMAGE_FLIP, 32'h0);
    check({31'h0, host_irq}, 32'h0);
    end_sim();
  end
endmodule
